// ==== rtl/swdmc_pkg.sv ====
// Package for the safety watchdog mode configuration block.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package swdmc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_RESTART = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_VALUE = 8'h10;
  // Mode register layout
  localparam logic [31:0] MODE_RESET = 32'h3FFFAFFF;
  localparam int POS_IDLE_HALT = 29;
  localparam int POS_DEBUG_HALT = 28;
  localparam int POS_KEY_LSB = 16;
  localparam int KEY_WIDTH = 12;
  localparam logic [11:0] KEY_VALUE = 12'hFFF;
  localparam int POS_OFF = 15;
  localparam int POS_RST_EN = 13;
  localparam int POS_FAULT_IEN = 12;
  localparam int RELOAD_WIDTH = 12;
  // Writable mode bits; bit 14 and 31:30 read as zero
  localparam logic [31:0] MODE_MASK = 32'h3FFFBFFF;
  // Restart register: bit 0 restarts, key in 31:24
  localparam int POS_RESTART = 0;
  localparam logic [7:0] RESTART_KEY = 8'hA5;
  // Status bits
  localparam int POS_ST_FAULT = 0;
  localparam int POS_ST_LOCKREJ = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // Slow clock: nominal 32768 Hz; divider from 200 MHz core clock
  localparam int CLOCK_HZ = 200000000;
  localparam int SLOW_HZ = 32768;
  localparam int SLOW_DIV = CLOCK_HZ / SLOW_HZ;
endpackage : swdmc_pkg

// ==== rtl/swdmc_top.sv ====
// Safety watchdog: write-once mode register, down counter, fault outputs.
// Assumes an APB master on CLOCK_I; idle/debug inputs come from other domains.
`timescale 1ns/10ps
module swdmc_top #(
  parameter int SLOW_DIV = swdmc_pkg::SLOW_DIV
) (
  // Clock, reset, enable
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CLK_EN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // System state, asynchronous
  input wire logic SYS_IDLE_I,
  input wire logic CPU_DEBUG_I,
  // Watchdog outputs
  output logic FAULT_RESET_O,
  output logic IRQ_O
);

  localparam int DW = $clog2(SLOW_DIV + 1);

  typedef struct packed {
    logic [31:0] mode;
    logic locked;
    logic [11:0] count;
    logic [DW-1:0] div;
    logic [1:0] status;
    logic [1:0] mask;
    logic fault_reset;
    logic [31:0] rdata;
    logic idle_s1;
    logic idle_s2;
    logic dbg_s1;
    logic dbg_s2;
  } swdmc_state_t;

  localparam swdmc_state_t ST_RESET = '{
    mode: swdmc_pkg::MODE_RESET,
    locked: 1'b0,
    count: 12'hFFF,
    div: '0,
    status: swdmc_pkg::STATUS_RESET,
    mask: swdmc_pkg::MASK_RESET,
    fault_reset: 1'b0,
    rdata: 32'h00000000,
    idle_s1: 1'b0,
    idle_s2: 1'b0,
    dbg_s1: 1'b0,
    dbg_s2: 1'b0
  };

  swdmc_state_t st;
  swdmc_state_t next_st;

  logic wr_access;
  logic rd_access;
  logic restart;
  logic halted;
  logic slow_tick;
  logic [1:0] set_ev;

  // Zero-wait APB: every access completes in its first access cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign PRDATA_O = st.rdata;
  assign FAULT_RESET_O = st.fault_reset;
  assign IRQ_O = |(st.status & st.mask);

  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_access = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign restart = wr_access && (PADDR_I == swdmc_pkg::OFF_RESTART)
    && PWDATA_I[swdmc_pkg::POS_RESTART] && (PWDATA_I[31:24] == swdmc_pkg::RESTART_KEY);
  assign halted = (st.mode[swdmc_pkg::POS_IDLE_HALT] && st.idle_s2)
    || (st.mode[swdmc_pkg::POS_DEBUG_HALT] && st.dbg_s2);
  assign slow_tick = (st.div == DW'(SLOW_DIV - 1));

  always_comb begin
    next_st = st;
    set_ev = 2'b00;
    next_st.idle_s1 = SYS_IDLE_I;
    next_st.idle_s2 = st.idle_s1;
    next_st.dbg_s1 = CPU_DEBUG_I;
    next_st.dbg_s2 = st.dbg_s1;
    next_st.div = slow_tick ? '0 : DW'(st.div + 1'b1);

    if (wr_access && PADDR_I == swdmc_pkg::OFF_MODE) begin
      if (st.locked) begin
        set_ev[swdmc_pkg::POS_ST_LOCKREJ] = 1'b1;
      end else begin
        next_st.mode = PWDATA_I & swdmc_pkg::MODE_MASK;
        next_st.locked = 1'b1;
        next_st.count = PWDATA_I[swdmc_pkg::RELOAD_WIDTH-1:0];
      end
    end

    if (restart) begin
      next_st.count = st.mode[swdmc_pkg::RELOAD_WIDTH-1:0];
      next_st.fault_reset = 1'b0;
    end else if (slow_tick && !halted && !st.mode[swdmc_pkg::POS_OFF]) begin
      if (st.count == 12'h000) begin
        if (st.mode[swdmc_pkg::POS_FAULT_IEN]) begin
          set_ev[swdmc_pkg::POS_ST_FAULT] = 1'b1;
        end
        if (st.mode[swdmc_pkg::POS_RST_EN]) begin
          next_st.fault_reset = 1'b1;
        end
        next_st.count = st.mode[swdmc_pkg::RELOAD_WIDTH-1:0];
      end else begin
        next_st.count = st.count - 12'h001;
      end
    end

    // Write-one-to-clear, new events win
    if (wr_access && PADDR_I == swdmc_pkg::OFF_STATUS) begin
      next_st.status = st.status & ~PWDATA_I[1:0];
    end
    next_st.status = next_st.status | set_ev;
    if (wr_access && PADDR_I == swdmc_pkg::OFF_MASK) begin
      next_st.mask = PWDATA_I[1:0];
    end

    if (rd_access) begin
      unique case (PADDR_I)
        swdmc_pkg::OFF_MODE: next_st.rdata = st.mode;
        swdmc_pkg::OFF_STATUS: next_st.rdata = {30'h0, st.status};
        swdmc_pkg::OFF_MASK: next_st.rdata = {30'h0, st.mask};
        swdmc_pkg::OFF_VALUE: next_st.rdata = {20'h0, st.count};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st <= ST_RESET;
    end else if (CLK_EN_I) begin
      st <= next_st;
    end
  end

endmodule : swdmc_top

// ==== sim/swdmc_sva.sv ====
// Checker for the watchdog top ports.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/10ps
module swdmc_chk (
  input wire logic CLOCK_I, RST_B_I, CLK_EN_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I, PRDATA_O,
  input wire logic PREADY_O, PSLVERR_O, SYS_IDLE_I, CPU_DEBUG_I, FAULT_RESET_O, IRQ_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  logic [1:0] st;
  logic [31:0] mv;
  wire acc = PSEL_I && PENABLE_I && CLK_EN_I;
  wire rd4 = acc && !PWRITE_I && PADDR_I == 8'h04;
  // Capture the mode value read back at each read after the first write
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st <= 2'h0;
      mv <= 32'h0;
    end else if (acc && PWRITE_I && PADDR_I == 8'h04 && st == 2'h0) begin
      st <= 2'h1;
    end else if (rd4 && st != 2'h0) begin
      st <= 2'h2;
      mv <= PRDATA_O;
    end
  end
  chk_mode_locked: assert property (rd4 && st == 2'h2 |-> PRDATA_O == mv)
    else $error("mode changed");
  chk_no_error: assert property (acc |-> PREADY_O && !PSLVERR_O)
    else $error("bus error");
  chk_mode_zeros: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == 8'h04
    |=> PRDATA_O[31:30] == 2'h0 && !PRDATA_O[14]) else $error("mode spare bits");
  chk_fault_hold: assert property ($fell(FAULT_RESET_O)
    |-> $past(acc && PWRITE_I && PADDR_I == 8'h00)) else $error("fault dropped");
  chk_irq_clear: assert property ($fell(IRQ_O) |-> $past(acc && PWRITE_I))
    else $error("irq dropped");
  cover property ($rose(FAULT_RESET_O));
  cover property ($rose(IRQ_O));
  cover property (rd4 && st == 2'h2);
endmodule : swdmc_chk

// ==== sim/swdmc_tb_top.sv ====
// Self-checking bench for the watchdog mode block.
// Assumes swdmc_pkg and swdmc_top compiled first; slow tick shortened.
`timescale 1ns/10ps
module swdmc_tb_top;
  logic CLOCK_I = 0, RST_B_I = 0, CLK_EN_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic SYS_IDLE_I = 1, CPU_DEBUG_I = 0, PREADY_O, PSLVERR_O, FAULT_RESET_O, IRQ_O;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd, mode, seed = 32'h619A;
  int errors = 0, checks_done = 0, cyc = 0;
  swdmc_top #(.SLOW_DIV(4)) swdmc_top_inst (.*);
  always #2.5 CLOCK_I = ~CLOCK_I;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end else $display("done %s", n);
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLOCK_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLOCK_I);
  endtask : apb
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    @(posedge CLOCK_I);
    apb(0, 8'h04, 0);
    chk("mode", swdmc_pkg::MODE_RESET, rd);
    seed = lfsr(seed);
    mode = 32'h2FFF3000 | {29'h0, seed[2:0]} + 32'h2;
    apb(1, 8'h04, mode);
    apb(1, 8'h04, 32'h0FFF8000);
    apb(0, 8'h04, 0);
    chk("mode", mode, rd);
    repeat (40) @(posedge CLOCK_I);
    apb(0, 8'h10, 0);
    chk("count", mode & 32'hFFF, rd);
    apb(1, 8'h0C, 32'h3);
    chk("irq", 1, IRQ_O);
    apb(0, 8'h08, 0);
    chk("status", 2, rd);
    apb(1, 8'h08, 32'h2);
    chk("irq", 0, IRQ_O);
    apb(0, 8'h14, 0);
    chk("unmapped", 0, rd);
    SYS_IDLE_I <= 1'b0;
    repeat (200) if (FAULT_RESET_O !== 1'b1) @(posedge CLOCK_I);
    chk("fault", 1, FAULT_RESET_O);
    chk("irq", 1, IRQ_O);
    apb(1, 8'h00, 32'hA5000001);
    chk("fault", 0, FAULT_RESET_O);
    apb(0, 8'h04, 0);
    chk("mode", mode, rd);
    CPU_DEBUG_I <= 1'b1;
    repeat (200) if (FAULT_RESET_O !== 1'b1) @(posedge CLOCK_I);
    chk("fault", 1, FAULT_RESET_O);
    summarize();
  end
endmodule : swdmc_tb_top
bind swdmc_top swdmc_chk swdmc_chk_inst (.*);
